// ---- inc/pmsc_pkg.sv ----
package pmsc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] PMSC_PMS_OFS = 8'h1d;
  localparam int PMSC_VPTR_HI = 15;
  localparam int PMSC_VPTR_LO = 7;
  localparam int PMSC_ROMDIS_BIT = 6;
  localparam int PMSC_RAM_OVL_BIT = 5;
  localparam int PMSC_ADDR_VIS_BIT = 4;
  localparam int PMSC_ROM_DATA_BIT = 3;
  localparam int PMSC_CLK_OFF_BIT = 2;
  localparam int PMSC_MUL_SAT_BIT = 1;
  localparam int PMSC_ST_SAT_BIT = 0;
  localparam logic [8:0] PMSC_VPTR_RST = 9'h1ff;
  localparam logic PMSC_FLAG_RST = 1'h0;
  localparam logic [15:0] PMSC_VEC_RST_ADDR = 16'hff80;
  localparam logic [6:0] PMSC_PAGE_OFS = 7'h00;

  // ------------------------------------------------------------
  // address ranges
  // ------------------------------------------------------------
  localparam logic [15:0] PMSC_RAM_LO = 16'h0080;
  localparam logic [15:0] PMSC_RAM_HI = 16'h9fff;
  localparam logic [15:0] PMSC_PROM_LO = 16'ha000;
  localparam logic [15:0] PMSC_PROM_HI = 16'hffff;
  localparam logic [15:0] PMSC_ROM_DATA_LO = 16'hc000;
  localparam logic [15:0] PMSC_ROM_DATA_HI = 16'hfeff;

  // ------------------------------------------------------------
  // clock output and saturation
  // ------------------------------------------------------------
  localparam logic [3:0] PMSC_CLK_PIN_HALF = 4'h1;
  localparam logic [31:0] PMSC_SAT_POS = 32'h7fffffff;
  localparam logic [31:0] PMSC_SAT_NEG = 32'h80000000;
endpackage

// ---- inc/pmsc_sat_if.sv ----
`timescale 1ns/10ps
interface pmsc_sat_if;
  logic mul_sat;
  logic st_sat;
  logic ovf_mode;
  logic frac_mode;
  logic prod_valid;
  logic signed [32:0] prod_in;
  logic [31:0] prod_out;
  logic store_valid;
  logic signed [39:0] acc_in;
  logic signed [4:0] shift;
  logic [31:0] store_out;

  modport core (
    output mul_sat, st_sat, ovf_mode, frac_mode, prod_valid, prod_in,
    output store_valid, acc_in, shift,
    input prod_out, store_out
  );
  modport sat (
    input mul_sat, st_sat, ovf_mode, frac_mode, prod_valid, prod_in,
    input store_valid, acc_in, shift,
    output prod_out, store_out
  );
endinterface

// ---- logic/pmsc_sat.sv ----
`timescale 1ns/10ps
module pmsc_sat (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  pmsc_sat_if.sat sif // saturation requests and results
);
  typedef struct packed {
    logic [31:0] prod;
    logic [31:0] store;
  } pmsc_sat_s;

  pmsc_sat_s st_reg;
  pmsc_sat_s st_next;
  logic signed [55:0] prod_ext;
  logic signed [55:0] acc_ext;
  logic signed [55:0] shifted;
  logic [4:0] mag;

  function automatic logic [31:0] pmsc_clamp32(input logic signed [55:0] v);
    if (v > 56'sd2147483647) begin
      return pmsc_pkg::PMSC_SAT_POS;
    end
    if (v < -56'sd2147483648) begin
      return pmsc_pkg::PMSC_SAT_NEG;
    end
    return v[31:0];
  endfunction

  // ------------------------------------------------------------
  // product and store paths
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    prod_ext = {{23{sif.prod_in[32]}}, sif.prod_in};
    acc_ext = {{16{sif.acc_in[39]}}, sif.acc_in};
    mag = sif.shift[4] ? 5'(-sif.shift) : sif.shift;
    // shift first, saturate after
    shifted = sif.shift[4] ? (acc_ext >>> mag) : (acc_ext <<< mag);
    if (sif.prod_valid) begin
      if (sif.mul_sat && sif.ovf_mode && sif.frac_mode) begin
        st_next.prod = pmsc_clamp32(prod_ext);
      end else begin
        st_next.prod = prod_ext[31:0];
      end
    end
    if (sif.store_valid) begin
      if (sif.st_sat) begin
        st_next.store = pmsc_clamp32(shifted);
      end else begin
        st_next.store = shifted[31:0];
      end
    end
    if (!rst_n) begin
      st_next = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  assign sif.prod_out = st_reg.prod;
  assign sif.store_out = st_reg.store;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_mul_sat_pos: assert property (
    sif.prod_valid && sif.mul_sat && sif.ovf_mode && sif.frac_mode &&
    sif.prod_in > 33'sh07fffffff |=> sif.prod_out == pmsc_pkg::PMSC_SAT_POS)
    else $error("product not saturated");
  a_mul_no_sat: assert property (
    sif.prod_valid && !sif.frac_mode
    |=> sif.prod_out == $past(sif.prod_in[31:0]))
    else $error("product saturated without fractional mode");
  a_store_sat_neg: assert property (
    sif.store_valid && sif.st_sat && sif.shift == 5'sh00 &&
    sif.acc_in < -40'sh0080000000 |=> sif.store_out == pmsc_pkg::PMSC_SAT_NEG)
    else $error("store not saturated");
endmodule

// ---- logic/pmsc_clock_output_pin.sv ----
`timescale 1ns/10ps
module pmsc_clock_output_pin (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clock_output_off, // hold the pin high
  output logic clock_output_pin // divided clock out
);
  typedef struct packed {
    logic [3:0] cnt;
    logic pin;
  } pmsc_clk_s;

  pmsc_clk_s st_reg;
  pmsc_clk_s st_next;
  logic tick;

  // ------------------------------------------------------------
  // divider enable and pin
  // ------------------------------------------------------------
  assign tick = (st_reg.cnt == pmsc_pkg::PMSC_CLK_PIN_HALF);

  always_comb begin
    st_next = st_reg;
    st_next.cnt = tick ? 4'h0 : 4'(st_reg.cnt + 4'h1);
    if (clock_output_off) begin
      st_next.pin = 1'b1;
    end else if (tick) begin
      st_next.pin = !st_reg.pin;
    end
    if (!rst_n) begin
      st_next = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  assign clock_output_pin = st_reg.pin;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_clk_held_high: assert property (
    clock_output_off |=> clock_output_pin)
    else $error("clock pin not held high");
endmodule

// ---- logic/pmsc_top.sv ----
`timescale 1ns/10ps
module pmsc_top (
  input wire logic core_clk, // core clock, 200 MHz
  input wire logic rst_n, // synchronous hardware reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic soft_reset_instr, // software reset instruction
  input wire logic rom_disable_mode_pin, // mode strap
  input wire logic [15:0] prog_addr, // internal program address
  input wire logic prog_fetch, // program address valid
  input wire logic [15:0] data_addr, // internal data address
  input wire logic data_access, // data address valid
  input wire logic [15:0] ext_addr, // external bus address
  input wire logic ext_access, // external bus cycle
  output logic [15:0] addr_pins, // external address pins
  output logic [15:0] vector_page_base, // vector table base
  output logic rom_disable_mode, // program rom removed
  output logic prog_rom_sel, // program fetch hits rom
  output logic prog_ram_sel, // program fetch hits ram
  output logic data_rom_sel, // data access hits rom
  output logic data_ram_sel, // data access hits ram
  output logic clock_output_pin, // clock output pin
  input wire logic overflow_mode, // overflow mode
  input wire logic fractional_mode, // fractional mode
  input wire logic prod_valid, // product of a mac or mas
  input wire logic signed [32:0] prod_in, // raw product
  output logic [31:0] prod_out, // product to accumulate
  input wire logic store_valid, // accumulator store
  input wire logic signed [39:0] acc_in, // accumulator value
  input wire logic signed [4:0] store_shift, // output shift
  output logic [31:0] store_out // data to memory
);
  typedef struct packed {
    logic [8:0] vec_ptr;
    logic rom_dis;
    logic ram_ovl;
    logic addr_vis;
    logic rom_in_data;
    logic clk_off;
    logic mul_sat;
    logic st_sat;
    logic [15:0] rdata;
    logic [15:0] pins;
    logic prog_rom;
    logic prog_ram;
    logic data_rom;
    logic data_ram;
  } pmsc_state_s;

  pmsc_state_s st_reg;
  pmsc_state_s st_next;
  logic hit;

  pmsc_sat_if sif ();

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic pmsc_in_range(
    input logic [15:0] a,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [15:0] pmsc_word(input pmsc_state_s s);
    return {s.vec_ptr, s.rom_dis, s.ram_ovl, s.addr_vis, s.rom_in_data,
            s.clk_off, s.mul_sat, s.st_sat};
  endfunction

  assign hit = (reg_addr == pmsc_pkg::PMSC_PMS_OFS);

  // ------------------------------------------------------------
  // register, decode and pin state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 16'h0000;
    // software reset restores the low flags only
    if (soft_reset_instr) begin
      st_next.ram_ovl = pmsc_pkg::PMSC_FLAG_RST;
      st_next.addr_vis = pmsc_pkg::PMSC_FLAG_RST;
      st_next.rom_in_data = pmsc_pkg::PMSC_FLAG_RST;
      st_next.clk_off = pmsc_pkg::PMSC_FLAG_RST;
      st_next.mul_sat = pmsc_pkg::PMSC_FLAG_RST;
      st_next.st_sat = pmsc_pkg::PMSC_FLAG_RST;
    end
    if (reg_wr && hit) begin
      st_next.vec_ptr =
        reg_wdata[pmsc_pkg::PMSC_VPTR_HI:pmsc_pkg::PMSC_VPTR_LO];
      st_next.rom_dis = reg_wdata[pmsc_pkg::PMSC_ROMDIS_BIT];
      st_next.ram_ovl = reg_wdata[pmsc_pkg::PMSC_RAM_OVL_BIT];
      st_next.addr_vis = reg_wdata[pmsc_pkg::PMSC_ADDR_VIS_BIT];
      st_next.rom_in_data = reg_wdata[pmsc_pkg::PMSC_ROM_DATA_BIT];
      st_next.clk_off = reg_wdata[pmsc_pkg::PMSC_CLK_OFF_BIT];
      st_next.mul_sat = reg_wdata[pmsc_pkg::PMSC_MUL_SAT_BIT];
      st_next.st_sat = reg_wdata[pmsc_pkg::PMSC_ST_SAT_BIT];
    end
    if (reg_rd && hit) begin
      st_next.rdata = pmsc_word(st_reg);
    end
    // external cycles always own the pins
    if (ext_access) begin
      st_next.pins = ext_addr;
    end else if (st_reg.addr_vis && prog_fetch) begin
      st_next.pins = prog_addr;
    end
    // ram wins over rom where both could answer
    st_next.prog_ram = prog_fetch && st_reg.ram_ovl &&
      pmsc_in_range(prog_addr, pmsc_pkg::PMSC_RAM_LO,
                    pmsc_pkg::PMSC_RAM_HI);
    st_next.prog_rom = prog_fetch && !st_reg.rom_dis &&
      !st_next.prog_ram &&
      pmsc_in_range(prog_addr, pmsc_pkg::PMSC_PROM_LO,
                    pmsc_pkg::PMSC_PROM_HI);
    st_next.data_ram = data_access &&
      pmsc_in_range(data_addr, pmsc_pkg::PMSC_RAM_LO,
                    pmsc_pkg::PMSC_RAM_HI);
    st_next.data_rom = data_access && st_reg.rom_in_data &&
      pmsc_in_range(data_addr, pmsc_pkg::PMSC_ROM_DATA_LO,
                    pmsc_pkg::PMSC_ROM_DATA_HI);
    if (!rst_n) begin
      st_next = '0;
      st_next.vec_ptr = pmsc_pkg::PMSC_VPTR_RST;
      st_next.rom_dis = rom_disable_mode_pin;
    end
  end

  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata = st_reg.rdata;
  assign addr_pins = st_reg.pins;
  assign vector_page_base = {st_reg.vec_ptr, pmsc_pkg::PMSC_PAGE_OFS};
  assign rom_disable_mode = st_reg.rom_dis;
  assign prog_rom_sel = st_reg.prog_rom;
  assign prog_ram_sel = st_reg.prog_ram;
  assign data_rom_sel = st_reg.data_rom;
  assign data_ram_sel = st_reg.data_ram;

  // ------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------
  assign sif.mul_sat = st_reg.mul_sat;
  assign sif.st_sat = st_reg.st_sat;
  assign sif.ovf_mode = overflow_mode;
  assign sif.frac_mode = fractional_mode;
  assign sif.prod_valid = prod_valid;
  assign sif.prod_in = prod_in;
  assign sif.store_valid = store_valid;
  assign sif.acc_in = acc_in;
  assign sif.shift = store_shift;
  assign prod_out = sif.prod_out;
  assign store_out = sif.store_out;

  pmsc_sat u_sat (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sif(sif.sat)
  );

  pmsc_clock_output_pin u_clock_output_pin (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clock_output_off(st_reg.clk_off),
    .clock_output_pin(clock_output_pin)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_reg_read;
    reg_rd && hit;
  endsequence

  sequence s_soft_reset_only;
    soft_reset_instr && !(reg_wr && hit);
  endsequence

  a_read_data: assert property (
    s_reg_read |=> reg_rdata == $past(pmsc_word(st_reg)))
    else $error("read data wrong");
  a_vector_reset: assert property (
    $rose(rst_n) |-> vector_page_base == pmsc_pkg::PMSC_VEC_RST_ADDR)
    else $error("vector base not ff80 after reset");
  a_soft_keeps_ptr: assert property (
    s_soft_reset_only |=> $stable(vector_page_base) &&
    $stable(rom_disable_mode) && !st_reg.ram_ovl)
    else $error("software reset disturbed the pointer");
  a_strap_load: assert property (
    $rose(rst_n) |-> rom_disable_mode == $past(rom_disable_mode_pin))
    else $error("mode strap not captured");
  a_rom_gate: assert property (
    prog_rom_sel |-> !$past(st_reg.rom_dis) && $past(prog_fetch))
    else $error("rom selected while disabled");
  a_ram_overlay_page0: assert property (
    prog_ram_sel |-> $past(st_reg.ram_ovl) &&
    $past(prog_addr) >= pmsc_pkg::PMSC_RAM_LO)
    else $error("ram in program space wrongly");
  a_addr_hold: assert property (
    !ext_access && !(st_reg.addr_vis && prog_fetch) |=> $stable(addr_pins))
    else $error("address pins moved");
  a_address_visibility_trace: assert property (
    st_reg.addr_vis && prog_fetch && !ext_access
    |=> addr_pins == $past(prog_addr))
    else $error("program address not traced");
  a_data_rom_map_map: assert property (
    data_rom_sel |-> $past(st_reg.rom_in_data) && $past(data_access))
    else $error("rom in data space wrongly");
endmodule

// ---- testbench/pmsc_ext_model.sv ----
`timescale 1ns/10ps
module pmsc_ext_model (
  input wire logic core_clk, // core clock
  input wire logic [15:0] addr_pins, // traced address pins
  output logic [15:0] ext_addr, // external bus address
  output logic ext_access // external bus cycle
);
  logic [15:0] trace_addr;

  initial begin
    ext_addr = 16'h0000;
    ext_access = 1'b0;
  end

  // the tracer latches whatever the pins show each cycle
  always @(posedge core_clk) begin
    trace_addr <= addr_pins;
  end

  // one bus cycle; the released address lines show the inverse afterwards
  task automatic cycle(input logic [15:0] a);
    @(posedge core_clk);
    ext_addr <= a;
    ext_access <= 1'b1;
    @(posedge core_clk);
    ext_access <= 1'b0;
    ext_addr <= ~a;
  endtask
endmodule

// ---- testbench/processor_mode_status_control_tb.sv ----
`timescale 1ns/10ps
module processor_mode_status_control_tb;
  logic core_clk, rst_n, reg_wr, reg_rd, soft_reset_instr, strap;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, prog_addr, data_addr, ext_addr;
  logic [15:0] addr_pins, vector_page_base;
  logic prog_fetch, data_access, ext_access, rom_disable_mode;
  logic prog_rom_sel, prog_ram_sel, data_rom_sel, data_ram_sel;
  logic clock_output_pin, overflow_mode, fractional_mode;
  logic prod_valid, store_valid;
  logic signed [32:0] prod_in;
  logic signed [39:0] acc_in;
  logic signed [4:0] store_shift;
  logic [31:0] prod_out, store_out;
  logic [15:0] d;
  int n_fail, comparisons, cycles, toggles;
  localparam logic [7:0] OFS = pmsc_pkg::PMSC_PMS_OFS;

  pmsc_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .soft_reset_instr(soft_reset_instr),
    .rom_disable_mode_pin(strap), .prog_addr(prog_addr),
    .prog_fetch(prog_fetch), .data_addr(data_addr),
    .data_access(data_access), .ext_addr(ext_addr),
    .ext_access(ext_access), .addr_pins(addr_pins),
    .vector_page_base(vector_page_base),
    .rom_disable_mode(rom_disable_mode), .prog_rom_sel(prog_rom_sel),
    .prog_ram_sel(prog_ram_sel), .data_rom_sel(data_rom_sel),
    .data_ram_sel(data_ram_sel), .clock_output_pin(clock_output_pin),
    .overflow_mode(overflow_mode), .fractional_mode(fractional_mode),
    .prod_valid(prod_valid), .prod_in(prod_in), .prod_out(prod_out),
    .store_valid(store_valid), .acc_in(acc_in),
    .store_shift(store_shift), .store_out(store_out));

  pmsc_ext_model u_ext (.core_clk(core_clk), .addr_pins(addr_pins),
    .ext_addr(ext_addr), .ext_access(ext_access));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic fetch(input logic [15:0] a, input logic dat);
    @(posedge core_clk);
    prog_addr <= a;
    data_addr <= a;
    prog_fetch <= 1'b1;
    data_access <= dat;
    @(posedge core_clk);
    prog_fetch <= 1'b0;
    data_access <= 1'b0;
    #1;
  endtask

  task automatic dec(input logic [15:0] pm, logic [15:0] a, logic [3:0] e);
    wr(OFS, pm);
    fetch(a, 1'b1);
    chk("selects", {28'h0000000, e},
      {28'h0000000, prog_rom_sel, prog_ram_sel, data_rom_sel, data_ram_sel});
  endtask

  task automatic sat(input logic pv, logic [39:0] v, logic [4:0] sh,
    logic [31:0] e);
    @(posedge core_clk);
    prod_valid <= pv;
    store_valid <= ~pv;
    prod_in <= v[32:0];
    acc_in <= v;
    store_shift <= sh;
    @(posedge core_clk);
    prod_valid <= 1'b0;
    store_valid <= 1'b0;
    #1 chk(pv ? "product" : "store", e, pv ? prod_out : store_out);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(OFS, d);
    chk("reset word", 32'h0000ffc0, {16'h0000, d});
    chk("vector base", 32'h0000ff80, {16'h0000, vector_page_base});
    strap <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("mode bit", 32'h00000001, {31'h0, rom_disable_mode});
  endtask

  task automatic t_regs();
    wr(OFS, 16'h0a80);
    rd(OFS, d);
    chk("word", 32'h00000a80, {16'h0000, d});
    chk("vector base", 32'h00000a80, {16'h0000, vector_page_base});
    wr(8'h1e, 16'hffff);
    rd(8'h1e, d);
    chk("unmapped", 32'h00000000, {16'h0000, d});
    rd(OFS, d);
    chk("word", 32'h00000a80, {16'h0000, d});
  endtask

  task automatic t_soft();
    wr(OFS, 16'h127f);
    @(posedge core_clk);
    soft_reset_instr <= 1'b1;
    @(posedge core_clk);
    soft_reset_instr <= 1'b0;
    rd(OFS, d);
    chk("soft reset word", 32'h00001240, {16'h0000, d});
  endtask

  task automatic t_pins();
    wr(OFS, 16'h1240);
    u_ext.cycle(16'h4321);
    fetch(16'h8888, 1'b0);
    chk("pins", 32'h00004321, {16'h0000, u_ext.trace_addr});
    wr(OFS, 16'h1250);
    fetch(16'h8888, 1'b0);
    chk("pins", 32'h00008888, {16'h0000, addr_pins});
  endtask

  task automatic t_clk();
    wr(OFS, 16'h0000);
    toggles = 0;
    #1 d[0] = clock_output_pin;
    repeat (8) begin
      @(posedge core_clk);
      #1 toggles += int'(clock_output_pin !== d[0]);
      d[0] = clock_output_pin;
    end
    chk("toggles", 32'd4, toggles);
    wr(OFS, 16'h0004);
    repeat (3) @(posedge core_clk);
    repeat (8) begin
      @(posedge core_clk);
      #1 chk("clock pin", 32'h1, {31'h0, clock_output_pin});
    end
  endtask

  task automatic t_sat();
    overflow_mode <= 1'b1;
    fractional_mode <= 1'b1;
    wr(OFS, 16'h0002);
    sat(1'b1, 40'h0080000000, 5'h00, 32'h7fffffff);
    sat(1'b1, 40'h0100000000, 5'h00, 32'h80000000);
    overflow_mode <= 1'b0;
    sat(1'b1, 40'h0080000000, 5'h00, 32'h80000000);
    wr(OFS, 16'h0000);
    overflow_mode <= 1'b1;
    sat(1'b1, 40'h0080000000, 5'h00, 32'h80000000);
    wr(OFS, 16'h0001);
    sat(1'b0, 40'h0080000000, 5'h00, 32'h7fffffff);
    sat(1'b0, 40'h0080000000, 5'h1c, 32'h08000000);
    sat(1'b0, 40'hff00000000, 5'h00, 32'h80000000);
    wr(OFS, 16'h0000);
    sat(1'b0, 40'h0080000000, 5'h00, 32'h80000000);
    wr(OFS, 16'h0002);
    fractional_mode <= 1'b0;
    sat(1'b1, 40'h0080000000, 5'h00, 32'h80000000);
  endtask

  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    rst_n = 1'b0;
    strap = 1'b1;
    {reg_wr, reg_rd, soft_reset_instr, prog_fetch, data_access} = 5'h00;
    {overflow_mode, fractional_mode, prod_valid, store_valid} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    prog_addr = 16'h0000;
    data_addr = 16'h0000;
    prod_in = 33'h000000000;
    acc_in = 40'h0000000000;
    store_shift = 5'h00;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_soft();
    t_pins();
    dec(16'h0000, 16'ha100, 4'h8);
    dec(16'h0040, 16'ha100, 4'h0);
    dec(16'h0020, 16'h0100, 4'h5);
    dec(16'h0020, 16'h0040, 4'h0);
    dec(16'h0008, 16'hc100, 4'ha);
    dec(16'h0000, 16'hc100, 4'h8);
    t_clk();
    t_sat();
    stop_test();
  end
endmodule
